// ---- rtl/sys_cycle_regs.svh ----
`ifndef SYS_CYCLE_REGS_SVH
`define SYS_CYCLE_REGS_SVH

// ----------------------------------------------------------------
// Command bus fields
// ----------------------------------------------------------------
`define CMD_W 12
`define CMD_TYPE_BIT 11
`define CMD_REQNUM_HI 10
`define CMD_REQNUM_LO 8
`define CMD_OP_HI 7
`define CMD_OP_LO 5
`define CMD_CAUSE_HI 4
`define CMD_CAUSE_LO 3
`define CMD_LOW_HI 2
`define CMD_LOW_LO 0
`define CMD_ECC_BIT 0
`define CMD_BAD_BIT 5
`define CMD_DTYPE_HI 4
`define CMD_DTYPE_LO 3

// ----------------------------------------------------------------
// Address/data bus fields in address cycles
// ----------------------------------------------------------------
`define AD_W 64
`define AD_TGT_HI 63
`define AD_TGT_LO 60
`define AD_UNC_HI 59
`define AD_UNC_LO 58
`define AD_WAY_BIT 57
`define AD_RSV_HI 56
`define AD_RSV_LO 40
`define AD_PA_HI 39
`define AD_PA_LO 0

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define TGT_NONE 4'h0
`define TGT_ALL 4'hf
`define SPECIAL_ELIMINATE 2'h1
`define WRITE_CAUSE_TYPICAL 2'h1
`define WRITE_CAUSE_UA_SEQ 2'h2
`define WRITE_CAUSE_UA_IDENT 2'h3

`endif

// ---- rtl/sys_cycle_pkg.sv ----
package sys_cycle_pkg;

	// Processor address-cycle command field
	typedef enum logic [2:0]
	{
		PRQ_READ_SHARED = 3'h0,
		PRQ_READ_EXCL = 3'h1,
		PRQ_READ_NONCOH = 3'h2,
		PRQ_READ_PARTIAL = 3'h3,
		PRQ_WRITE_BLOCK = 3'h4,
		PRQ_WRITE_PARTIAL = 3'h5,
		PRQ_UPGRADE = 3'h6,
		PRQ_SPECIAL = 3'h7
	} proc_cmd_type;

	// External address-cycle command field
	typedef enum logic [2:0]
	{
		XRQ_INTV_SHARED = 3'h0,
		XRQ_INTV_EXCL = 3'h1,
		XRQ_ALLOC_A = 3'h2,
		XRQ_ALLOC_B = 3'h3,
		XRQ_NOP_A = 3'h4,
		XRQ_NOP_B = 3'h5,
		XRQ_INVALIDATE = 3'h6,
		XRQ_SPECIAL = 3'h7
	} ext_cmd_type;

	// Data-cycle type field
	typedef enum logic [1:0]
	{
		DT_REQ = 2'h0,
		DT_RESP = 2'h1,
		DT_REQ_LAST = 2'h2,
		DT_RESP_LAST = 2'h3
	} data_type_type;

endpackage

// ---- rtl/sys_cycle_if.sv ----
`include "sys_cycle_regs.svh"

// Shared bus between processor end and agent end; each end drives its own
// half with an enable; the checker flags both enables high in one clock.
interface sys_cycle_if;
	logic [`CMD_W-1:0] proc_cmd;
	logic [`AD_W-1:0] proc_ad;
	logic proc_oe;
	logic [`CMD_W-1:0] agent_cmd;
	logic [`AD_W-1:0] agent_ad;
	logic agent_oe;

	modport proc_end
	(
		output proc_cmd,
		output proc_ad,
		output proc_oe,
		input agent_cmd,
		input agent_ad,
		input agent_oe
	);

	modport agent_end
	(
		input proc_cmd,
		input proc_ad,
		input proc_oe,
		output agent_cmd,
		output agent_ad,
		output agent_oe
	);
endinterface

// ---- rtl/cmd_field_decode.sv ----
`include "sys_cycle_regs.svh"

// ----------------------------------------------------------------
// Splits a captured command/address word into its fields
// ----------------------------------------------------------------
module cmd_field_decode
(
	// Captured cycle
	input wire logic [`CMD_W-1:0] cmd,
	input wire logic [`AD_W-1:0] ad,
	// Decoded fields
	output logic is_data,
	output logic [2:0] req_num,
	output logic [2:0] op,
	output logic [1:0] cause,
	output logic [2:0] low,
	output logic ecc_en,
	output logic bad_data,
	output logic [3:0] target,
	output logic [1:0] uncached,
	output logic way,
	output logic [39:0] phys_addr
);
	// Pure wiring of fields; reserved address bits are simply not exported
	always_comb
	begin
		is_data = cmd[`CMD_TYPE_BIT];
		req_num = cmd[`CMD_REQNUM_HI:`CMD_REQNUM_LO];
		op = cmd[`CMD_OP_HI:`CMD_OP_LO];
		cause = cmd[`CMD_CAUSE_HI:`CMD_CAUSE_LO];
		low = cmd[`CMD_LOW_HI:`CMD_LOW_LO];
		ecc_en = cmd[`CMD_ECC_BIT];
		bad_data = cmd[`CMD_BAD_BIT];
		target = ad[`AD_TGT_HI:`AD_TGT_LO];
		uncached = ad[`AD_UNC_HI:`AD_UNC_LO];
		way = ad[`AD_WAY_BIT];
		phys_addr = ad[`AD_PA_HI:`AD_PA_LO];
	end
endmodule

// ---- rtl/proc_end.sv ----
`include "sys_cycle_regs.svh"

// How it works
// - Command bit 11: address 0, data 1
// - Bits 7:5 encode processor request kind
// - Request number on reads, upgrades; zero on writes
// - Address word: target, uncached, way, address
// - Way bit on block, upgrade, eliminate cycles
// - Agent targets processors by device number bit
// - Non-coherent requests drive zero target
// - Mode off: coherent requests drive zero target
// - Mode on: coherent requests drive all-ones target
// - System sets mode for snoopy protocols
// - Uncached attribute on partial and accelerated writes
// - Agent encodes external commands in bits 7:5
// - Bit 0 enables check; set on block cycles except accelerated writes
// - Data cycles: bit 5 bad, 4:3 type
module proc_end
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Mode
	input wire logic coherent_target_mode,
	input wire logic [1:0] device_number,
	// Request issue
	input wire logic req_valid,
	input wire sys_cycle_pkg::proc_cmd_type req_cmd,
	input wire logic [2:0] req_num,
	input wire logic [1:0] req_cause,
	input wire logic [2:0] req_low,
	input wire logic [1:0] req_uncached,
	input wire logic req_way,
	input wire logic [39:0] req_addr,
	// Data cycle issue
	input wire logic dat_valid,
	input wire logic [2:0] dat_req_num,
	input wire logic dat_bad,
	input wire sys_cycle_pkg::data_type_type dat_type,
	input wire logic [1:0] dat_state,
	input wire logic [63:0] dat_word,
	// External address cycle seen
	output logic ext_valid,
	output logic ext_for_me,
	output sys_cycle_pkg::ext_cmd_type ext_cmd,
	output logic [2:0] ext_req_num,
	output logic [1:0] ext_cause,
	output logic ext_ecc_en,
	output logic [39:0] ext_addr,
	// External data cycle seen
	output logic ext_dat_valid,
	output logic ext_dat_bad,
	output sys_cycle_pkg::data_type_type ext_dat_type,
	output logic [63:0] ext_dat_word,
	// Bus
	sys_cycle_if.proc_end bus
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// True for a coherent block read or upgrade
	function automatic logic is_coherent(input sys_cycle_pkg::proc_cmd_type c);
		is_coherent = (c == sys_cycle_pkg::PRQ_READ_SHARED) || (c == sys_cycle_pkg::PRQ_READ_EXCL)
			|| (c == sys_cycle_pkg::PRQ_UPGRADE);
	endfunction

	// True for eliminate: special with its cause code
	function automatic logic is_elim(input sys_cycle_pkg::proc_cmd_type c, input logic [1:0] cs);
		is_elim = (c == sys_cycle_pkg::PRQ_SPECIAL) && (cs == `SPECIAL_ELIMINATE);
	endfunction

	// True for block read/write, upgrade or eliminate
	function automatic logic is_block(input sys_cycle_pkg::proc_cmd_type c, input logic [1:0] cs);
		is_block = is_coherent(c) || (c == sys_cycle_pkg::PRQ_READ_NONCOH)
			|| (c == sys_cycle_pkg::PRQ_WRITE_BLOCK) || is_elim(c, cs);
	endfunction

	// ----------------------------------------------------------------
	// Outgoing encoder
	// ----------------------------------------------------------------
	logic [`CMD_W-1:0] cmd_d, cmd_q; // Command word driven
	logic [`AD_W-1:0] ad_d, ad_q; // Address/data word driven
	logic oe_d, oe_q; // Drive enable

	// Address cycle wins over data cycle if both asked in one clock
	always_comb
	begin
		cmd_d = '0;
		ad_d = '0;
		oe_d = 1'b0;
		if (req_valid)
		begin
			oe_d = 1'b1;
			cmd_d[`CMD_TYPE_BIT] = 1'b0;
			cmd_d[`CMD_OP_HI:`CMD_OP_LO] = req_cmd;
			cmd_d[`CMD_CAUSE_HI:`CMD_CAUSE_LO] = req_cause;
			cmd_d[`CMD_LOW_HI:`CMD_LOW_LO] = req_low;
			// Reads and upgrades carry their number, writes carry zero
			case (req_cmd)
				sys_cycle_pkg::PRQ_READ_SHARED, sys_cycle_pkg::PRQ_READ_EXCL, sys_cycle_pkg::PRQ_READ_NONCOH,
				sys_cycle_pkg::PRQ_READ_PARTIAL, sys_cycle_pkg::PRQ_UPGRADE:
					cmd_d[`CMD_REQNUM_HI:`CMD_REQNUM_LO] = req_num;
				default:
					cmd_d[`CMD_REQNUM_HI:`CMD_REQNUM_LO] = 3'h0;
			endcase
			// Check-enable bit forced on block-class cycles, except accelerated writes
			if (is_block(req_cmd, req_cause) && !((req_cmd == sys_cycle_pkg::PRQ_WRITE_BLOCK)
				&& (req_cause != `WRITE_CAUSE_TYPICAL)))
			begin
				cmd_d[`CMD_ECC_BIT] = 1'b1;
			end
			// Target indication
			if (is_coherent(req_cmd))
			begin
				ad_d[`AD_TGT_HI:`AD_TGT_LO] = coherent_target_mode ? `TGT_ALL : `TGT_NONE;
			end
			else
			begin
				ad_d[`AD_TGT_HI:`AD_TGT_LO] = `TGT_NONE;
			end
			// Uncached attribute only where it means something
			if ((req_cmd == sys_cycle_pkg::PRQ_READ_PARTIAL) || (req_cmd == sys_cycle_pkg::PRQ_WRITE_PARTIAL)
				|| ((req_cmd == sys_cycle_pkg::PRQ_WRITE_BLOCK) && (req_cause != `WRITE_CAUSE_TYPICAL)))
			begin
				ad_d[`AD_UNC_HI:`AD_UNC_LO] = req_uncached;
			end
			if (is_block(req_cmd, req_cause))
			begin
				ad_d[`AD_WAY_BIT] = req_way;
			end
			ad_d[`AD_PA_HI:`AD_PA_LO] = req_addr;
		end
		else if (dat_valid)
		begin
			oe_d = 1'b1;
			cmd_d[`CMD_TYPE_BIT] = 1'b1;
			cmd_d[`CMD_REQNUM_HI:`CMD_REQNUM_LO] = dat_req_num;
			cmd_d[`CMD_BAD_BIT] = dat_bad;
			cmd_d[`CMD_DTYPE_HI:`CMD_DTYPE_LO] = dat_type;
			cmd_d[2:1] = dat_state;
			cmd_d[`CMD_ECC_BIT] = 1'b1; // Processor data cycles always enable checking
			ad_d = dat_word;
		end
	end

	// Registers the driven bus
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			cmd_q <= '0;
			ad_q <= '0;
			oe_q <= 1'b0;
		end
		else
		begin
			cmd_q <= cmd_d;
			ad_q <= ad_d;
			oe_q <= oe_d;
		end
	end

	assign bus.proc_cmd = cmd_q;
	assign bus.proc_ad = ad_q;
	assign bus.proc_oe = oe_q;

	// ----------------------------------------------------------------
	// Incoming decoder
	// ----------------------------------------------------------------
	logic [`CMD_W-1:0] in_cmd_s1, in_cmd_s2; // Synchroniser stages
	logic [`AD_W-1:0] in_ad_s1, in_ad_s2;
	logic in_oe_s1, in_oe_s2;
	logic f_data, f_ecc, f_bad;
	logic [2:0] f_num, f_op;
	logic [1:0] f_cause;
	logic [3:0] f_tgt;
	logic [39:0] f_pa;

	// Two-stage capture of the far end's drive
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			in_cmd_s1 <= '0;
			in_cmd_s2 <= '0;
			in_ad_s1 <= '0;
			in_ad_s2 <= '0;
			in_oe_s1 <= 1'b0;
			in_oe_s2 <= 1'b0;
		end
		else
		begin
			in_cmd_s1 <= bus.agent_cmd;
			in_cmd_s2 <= in_cmd_s1;
			in_ad_s1 <= bus.agent_ad;
			in_ad_s2 <= in_ad_s1;
			in_oe_s1 <= bus.agent_oe;
			in_oe_s2 <= in_oe_s1;
		end
	end

	cmd_field_decode u_dec
	(
		.cmd(in_cmd_s2),
		.ad(in_ad_s2),
		.is_data(f_data),
		.req_num(f_num),
		.op(f_op),
		.cause(f_cause),
		.low(),
		.ecc_en(f_ecc),
		.bad_data(f_bad),
		.target(f_tgt),
		.uncached(),
		.way(),
		.phys_addr(f_pa)
	);

	logic ev_d, ev_q, em_d, em_q, dv_d, dv_q;
	sys_cycle_pkg::ext_cmd_type ec_d, ec_q;
	logic [2:0] en_q;
	logic [1:0] ecs_q, dt_q;
	logic ee_q, db_q;
	logic [39:0] ea_q;
	logic [63:0] dw_q;

	// Classify incoming cycle; reserved bits reach no output but ext_dat_word, which takes the whole word
	always_comb
	begin
		ev_d = in_oe_s2 && !f_data;
		dv_d = in_oe_s2 && f_data;
		em_d = f_tgt[device_number];
		ec_d = sys_cycle_pkg::ext_cmd_type'(f_op);
	end

	// Registers the decoded view
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			ev_q <= 1'b0;
			em_q <= 1'b0;
			dv_q <= 1'b0;
			ec_q <= sys_cycle_pkg::XRQ_INTV_SHARED;
			en_q <= 3'h0;
			ecs_q <= 2'h0;
			ee_q <= 1'b0;
			ea_q <= '0;
			db_q <= 1'b0;
			dt_q <= 2'h0;
			dw_q <= '0;
		end
		else
		begin
			ev_q <= ev_d;
			em_q <= em_d;
			dv_q <= dv_d;
			ec_q <= ec_d;
			en_q <= f_num;
			ecs_q <= f_cause;
			ee_q <= f_ecc;
			ea_q <= f_pa;
			db_q <= f_bad;
			dt_q <= f_cause;
			dw_q <= in_ad_s2;
		end
	end

	assign ext_valid = ev_q;
	assign ext_for_me = em_q;
	assign ext_cmd = ec_q;
	assign ext_req_num = en_q;
	assign ext_cause = ecs_q;
	assign ext_ecc_en = ee_q;
	assign ext_addr = ea_q;
	assign ext_dat_valid = dv_q;
	assign ext_dat_bad = db_q;
	assign ext_dat_type = sys_cycle_pkg::data_type_type'(dt_q);
	assign ext_dat_word = dw_q;
endmodule

// ---- rtl/agent_end.sv ----
`include "sys_cycle_regs.svh"

// ----------------------------------------------------------------
// External agent end: encodes external cycles, decodes processor ones
// ----------------------------------------------------------------
module agent_end
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// External request issue
	input wire logic xreq_valid,
	input wire sys_cycle_pkg::ext_cmd_type xreq_cmd,
	input wire logic [2:0] xreq_num,
	input wire logic [1:0] xreq_cause,
	input wire logic xreq_ecc,
	input wire logic [3:0] xreq_target,
	input wire logic [39:0] xreq_addr,
	// External data issue
	input wire logic xdat_valid,
	input wire logic [2:0] xdat_num,
	input wire logic xdat_bad,
	input wire sys_cycle_pkg::data_type_type xdat_type,
	input wire logic [1:0] xdat_state,
	input wire logic xdat_ecc,
	input wire logic [63:0] xdat_word,
	// Processor address cycle seen
	output logic preq_valid,
	output sys_cycle_pkg::proc_cmd_type preq_cmd,
	output logic [2:0] preq_num,
	output logic [3:0] preq_target,
	output logic [1:0] preq_uncached,
	output logic preq_way,
	output logic preq_ecc,
	output logic [39:0] preq_addr,
	// Processor data cycle seen
	output logic pdat_valid,
	output logic pdat_bad,
	output logic [63:0] pdat_word,
	// Bus
	sys_cycle_if.agent_end bus
);
	logic [`CMD_W-1:0] cmd_d, cmd_q; // Command word driven
	logic [`AD_W-1:0] ad_d, ad_q; // Address/data word driven
	logic oe_d, oe_q;

	// Address cycle wins over data cycle in one clock
	always_comb
	begin
		cmd_d = '0;
		ad_d = '0;
		oe_d = 1'b0;
		if (xreq_valid)
		begin
			oe_d = 1'b1;
			cmd_d[`CMD_TYPE_BIT] = 1'b0;
			cmd_d[`CMD_REQNUM_HI:`CMD_REQNUM_LO] = xreq_num;
			cmd_d[`CMD_OP_HI:`CMD_OP_LO] = xreq_cmd;
			cmd_d[`CMD_CAUSE_HI:`CMD_CAUSE_LO] = xreq_cause;
			cmd_d[`CMD_ECC_BIT] = xreq_ecc;
			ad_d[`AD_TGT_HI:`AD_TGT_LO] = xreq_target;
			ad_d[`AD_PA_HI:`AD_PA_LO] = xreq_addr;
		end
		else if (xdat_valid)
		begin
			oe_d = 1'b1;
			cmd_d[`CMD_TYPE_BIT] = 1'b1;
			cmd_d[`CMD_REQNUM_HI:`CMD_REQNUM_LO] = xdat_num;
			cmd_d[`CMD_BAD_BIT] = xdat_bad;
			cmd_d[`CMD_DTYPE_HI:`CMD_DTYPE_LO] = xdat_type;
			cmd_d[2:1] = xdat_state;
			cmd_d[`CMD_ECC_BIT] = xdat_ecc;
			ad_d = xdat_word;
		end
	end

	// Registers the driven bus
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			cmd_q <= '0;
			ad_q <= '0;
			oe_q <= 1'b0;
		end
		else
		begin
			cmd_q <= cmd_d;
			ad_q <= ad_d;
			oe_q <= oe_d;
		end
	end

	assign bus.agent_cmd = cmd_q;
	assign bus.agent_ad = ad_q;
	assign bus.agent_oe = oe_q;

	// Same-clock logic drives the processor half, so no synchroniser here
	logic f_data, f_ecc, f_bad, f_way;
	logic [2:0] f_num, f_op;
	logic [1:0] f_unc;
	logic [3:0] f_tgt;
	logic [39:0] f_pa;

	cmd_field_decode u_dec
	(
		.cmd(bus.proc_cmd),
		.ad(bus.proc_ad),
		.is_data(f_data),
		.req_num(f_num),
		.op(f_op),
		.cause(),
		.low(),
		.ecc_en(f_ecc),
		.bad_data(f_bad),
		.target(f_tgt),
		.uncached(f_unc),
		.way(f_way),
		.phys_addr(f_pa)
	);

	// Registers the decoded view of the processor's cycle
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			preq_valid <= 1'b0;
			preq_cmd <= sys_cycle_pkg::PRQ_READ_SHARED;
			preq_num <= 3'h0;
			preq_target <= 4'h0;
			preq_uncached <= 2'h0;
			preq_way <= 1'b0;
			preq_ecc <= 1'b0;
			preq_addr <= '0;
			pdat_valid <= 1'b0;
			pdat_bad <= 1'b0;
			pdat_word <= '0;
		end
		else
		begin
			preq_valid <= bus.proc_oe && !f_data;
			preq_cmd <= sys_cycle_pkg::proc_cmd_type'(f_op);
			preq_num <= f_num;
			preq_target <= f_tgt;
			preq_uncached <= f_unc;
			preq_way <= f_way;
			preq_ecc <= f_ecc;
			preq_addr <= f_pa;
			pdat_valid <= bus.proc_oe && f_data;
			pdat_bad <= f_bad;
			pdat_word <= bus.proc_ad;
		end
	end
endmodule

// ---- verification/sys_cycle_chk.sv ----
`include "sys_cycle_regs.svh"

// ----------------------------------------------------------------
// Wire checks on what the processor end drives, plus one-driver and agent address checks
// ----------------------------------------------------------------
module sys_cycle_chk
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Shared bus, both halves
	input wire logic [`CMD_W-1:0] proc_cmd,
	input wire logic [`AD_W-1:0] proc_ad,
	input wire logic proc_oe,
	input wire logic [`CMD_W-1:0] agent_cmd,
	input wire logic [`AD_W-1:0] agent_ad,
	input wire logic agent_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// Processor address cycle flag and its command field
	logic pa;
	logic [2:0] op;
	assign pa = proc_oe && !proc_cmd[`CMD_TYPE_BIT];
	assign op = proc_cmd[`CMD_OP_HI:`CMD_OP_LO];

	a_reserved_zero: assert property (pa |-> proc_ad[56:40] == 17'h0)
		else $error("reserved address bits not zero");
	a_write_no_num: assert property (pa && op inside {3'h4, 3'h5} |-> proc_cmd[10:8] == 3'h0)
		else $error("write cycle carries a request number");
	a_plain_target: assert property (pa && op inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h7} |-> proc_ad[63:60] == 4'h0)
		else $error("non-coherent cycle has a target");
	a_coh_target: assert property (pa && op inside {3'h0, 3'h1, 3'h6} |-> proc_ad[63:60] inside {4'h0, 4'hf})
		else $error("coherent cycle target neither none nor all");
	a_block_check: assert property (pa && op inside {3'h0, 3'h1, 3'h2, 3'h6} |-> proc_cmd[0])
		else $error("block cycle without check bit");
	a_unc_clear: assert property (pa && op inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7} |-> proc_ad[59:58] == 2'h0)
		else $error("uncached attribute on a cached cycle");
	a_way_clear: assert property (pa && op inside {3'h3, 3'h5} |-> !proc_ad[57])
		else $error("way bit on a partial-word cycle");
	a_data_check: assert property (proc_oe && proc_cmd[`CMD_TYPE_BIT] |-> proc_cmd[0])
		else $error("processor data cycle without check bit");
	a_one_driver: assert property (!(proc_oe && agent_oe))
		else $error("both ends drive the bus");
	a_agent_fields: assert property (agent_oe && !agent_cmd[`CMD_TYPE_BIT] |-> agent_ad[59:40] == 20'h0)
		else $error("agent address cycle drives unused address bits");
endmodule

// ---- verification/tb_system_bus_cycle_encoding.sv ----
// ----------------------------------------------------------------
// Bench joining the processor end and the agent end
// ----------------------------------------------------------------
module tb_system_bus_cycle_encoding;
	timeunit 1ns;
	timeprecision 1ps;
	// Clock, reset, tallies
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	int err_total = 0;
	int n_tests = 0;
	// Processor side stimulus
	logic mode = 1'b0;
	logic [1:0] dev_num = 2'h2;
	logic req_valid = 1'b0;
	sys_cycle_pkg::proc_cmd_type req_cmd = sys_cycle_pkg::PRQ_READ_SHARED;
	logic [2:0] req_num = 3'h0;
	logic [1:0] req_cause = 2'h0;
	logic req_way = 1'b0;
	logic [39:0] req_addr = 40'h0;
	logic dat_valid = 1'b0;
	logic dat_bad = 1'b0;
	sys_cycle_pkg::data_type_type dat_type = sys_cycle_pkg::DT_REQ;
	logic [63:0] dat_word = 64'h0;
	// Agent side stimulus
	logic xreq_valid = 1'b0;
	sys_cycle_pkg::ext_cmd_type xreq_cmd = sys_cycle_pkg::XRQ_INTV_SHARED;
	logic xreq_ecc = 1'b0;
	logic [3:0] xreq_target = 4'h0;
	logic xdat_valid = 1'b0;
	sys_cycle_pkg::data_type_type xdat_type = sys_cycle_pkg::DT_REQ;
	// Outputs of both ends
	logic ext_valid, ext_for_me, ext_ecc_en, ext_dat_valid, ext_dat_bad, preq_valid, preq_way, preq_ecc;
	logic pdat_valid, pdat_bad;
	sys_cycle_pkg::ext_cmd_type ext_cmd;
	sys_cycle_pkg::proc_cmd_type preq_cmd;
	sys_cycle_pkg::data_type_type ext_dat_type;
	logic [2:0] ext_req_num, preq_num;
	logic [1:0] ext_cause, preq_uncached;
	logic [3:0] preq_target;
	logic [39:0] ext_addr, preq_addr;
	logic [63:0] ext_dat_word, pdat_word;

	sys_cycle_if bus_if();

	proc_end proc_end_inst (.sys_clk(sys_clk), .nrst(nrst), .coherent_target_mode(mode), .device_number(dev_num),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_num(req_num), .req_cause(req_cause), .req_low(3'h6),
		.req_uncached(req_num[1:0]), .req_way(req_way), .req_addr(req_addr), .dat_valid(dat_valid),
		.dat_req_num(req_num),
		.dat_bad(dat_bad), .dat_type(dat_type), .dat_state(req_cause), .dat_word(dat_word), .ext_valid(ext_valid),
		.ext_for_me(ext_for_me), .ext_cmd(ext_cmd), .ext_req_num(ext_req_num), .ext_cause(ext_cause),
		.ext_ecc_en(ext_ecc_en), .ext_addr(ext_addr), .ext_dat_valid(ext_dat_valid), .ext_dat_bad(ext_dat_bad),
		.ext_dat_type(ext_dat_type), .ext_dat_word(ext_dat_word), .bus(bus_if));

	agent_end agent_end_inst (.sys_clk(sys_clk), .nrst(nrst), .xreq_valid(xreq_valid), .xreq_cmd(xreq_cmd),
		.xreq_num(req_num), .xreq_cause(req_cause), .xreq_ecc(xreq_ecc), .xreq_target(xreq_target),
		.xreq_addr(req_addr), .xdat_valid(xdat_valid), .xdat_num(req_num), .xdat_bad(dat_bad), .xdat_type(xdat_type),
		.xdat_state(req_cause), .xdat_ecc(xreq_ecc), .xdat_word(dat_word), .preq_valid(preq_valid),
		.preq_cmd(preq_cmd), .preq_num(preq_num), .preq_target(preq_target), .preq_uncached(preq_uncached),
		.preq_way(preq_way), .preq_ecc(preq_ecc), .preq_addr(preq_addr), .pdat_valid(pdat_valid),
		.pdat_bad(pdat_bad), .pdat_word(pdat_word), .bus(bus_if));

	sys_cycle_chk sys_cycle_chk_inst (.sys_clk(sys_clk), .nrst(nrst), .proc_cmd(bus_if.proc_cmd),
		.proc_ad(bus_if.proc_ad), .proc_oe(bus_if.proc_oe), .agent_cmd(bus_if.agent_cmd),
		.agent_ad(bus_if.agent_ad), .agent_oe(bus_if.agent_oe));

	// Free-running clock, 100 MHz
	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end

	// Compare one value, count it, report a mismatch at once
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single exit point of the run
	task print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Bounded wait on one of the receive strobes; a miss ends the run
	task wait_hi(input int sel);
		logic s;
		for (int k = 0; k < 8; k++)
		begin
			@(posedge sys_clk);
			#1;
			s = (sel == 0) ? preq_valid : (sel == 1) ? pdat_valid : (sel == 2) ? ext_valid : ext_dat_valid;
			if (s === 1'b1)
				return;
		end
		err_total++;
		print_verdict();
	endtask

	// Expected command word; request number per op is op xor 2 on reads and upgrades, bits 2:1 are 3, bit 0 is the check bit
	function automatic logic [11:0] exp_cmd(int op, logic [1:0] c);
		logic chk_on;
		chk_on = op inside {0, 1, 2, 6} || (op inside {4, 7} && c == 2'h1);
		return {1'b0, (op inside {0, 1, 2, 3, 6}) ? (3'(op) ^ 3'h2) : 3'h0, 3'(op), c, 2'h3, chk_on};
	endfunction

	// Expected address word: target, uncached, way, zero reserved, address
	function automatic logic [63:0] exp_ad(int op, logic [1:0] c, logic m);
		logic [3:0] t;
		logic [1:0] u;
		logic w;
		t = (m && op inside {0, 1, 6}) ? 4'hf : 4'h0;
		u = (op inside {3, 5} || (op == 4 && c != 2'h1)) ? (2'(op) ^ 2'h2) : 2'h0;
		w = (op inside {0, 1, 2, 4, 6} || (op == 7 && c == 2'h1)) && (op % 2 == 1);
		return {t, u, w, 17'h0, 40'hfe_dcba_9870 + 40'(op)};
	endfunction

	// One processor address cycle, judged on the wire and at the agent
	task proc_req(input int op, input logic [1:0] c);
		logic [63:0] ea;
		logic [11:0] ec;
		@(posedge sys_clk);
		ea = exp_ad(op, c, mode);
		ec = exp_cmd(op, c);
		req_valid <= 1'b1;
		req_cmd <= sys_cycle_pkg::proc_cmd_type'(op);
		req_num <= 3'(op) ^ 3'h2;
		req_cause <= c;
		req_way <= op % 2 == 1;
		req_addr <= 40'hfe_dcba_9870 + 40'(op);
		@(posedge sys_clk);
		req_valid <= 1'b0;
		#1;
		chk(64'(bus_if.proc_cmd), 64'(ec));
		chk(bus_if.proc_ad, ea);
		wait_hi(0);
		chk(64'({preq_cmd, preq_target, preq_uncached, preq_way, preq_addr}), 64'({3'(op), ea[63:57], ea[39:0]}));
		chk(64'({preq_num, preq_ecc}), 64'({ec[10:8], ec[0]}));
	endtask

	// Every processor command with the coherent target mode off
	task scen_proc_map();
		for (int op = 0; op < 8; op++)
			proc_req(op, 2'h1);
	endtask

	// Coherent target mode on: all-ones only on coherent reads and upgrades
	task scen_coh_mode();
		@(posedge sys_clk);
		mode <= 1'b1;
		proc_req(0, 2'h1);
		proc_req(1, 2'h1);
		proc_req(6, 2'h1);
		proc_req(2, 2'h1);
		@(posedge sys_clk);
		mode <= 1'b0;
	endtask

	// Accelerated block writes carry the uncached attribute, no forced check
	task scen_unc_write();
		proc_req(4, 2'h2);
		proc_req(4, 2'h3);
	endtask

	// Processor data cycles of every type, bad flag toggling
	task scen_proc_data();
		for (int t = 0; t < 4; t++)
		begin
			@(posedge sys_clk);
			dat_valid <= 1'b1;
			dat_bad <= t[0];
			dat_type <= sys_cycle_pkg::data_type_type'(t);
			dat_word <= 64'h0123_4567_89ab_cdef ^ 64'(t);
			@(posedge sys_clk);
			dat_valid <= 1'b0;
			#1;
			chk(64'({bus_if.proc_cmd[11], bus_if.proc_cmd[5:3], bus_if.proc_cmd[0]}), 64'({1'b1, t[0], 2'(t), 1'b1}));
			wait_hi(1);
			chk(pdat_word ^ 64'(pdat_bad), 64'h0123_4567_89ab_cdef ^ 64'(t) ^ 64'(t[0]));
		end
	endtask

	// Every external command, then an external data cycle, to the processor
	task scen_ext();
		logic [3:0] xt;
		for (int c = 0; c < 8; c++)
		begin
			@(posedge sys_clk);
			xt = c[1] ? 4'h4 : 4'hb;
			xreq_valid <= 1'b1;
			xreq_cmd <= sys_cycle_pkg::ext_cmd_type'(c);
			xreq_ecc <= c[0];
			xreq_target <= xt;
			dev_num <= 2'(c >> 1);
			req_num <= 3'(c);
			req_cause <= 2'(c);
			req_addr <= 40'h12_3456_7800 + 40'(c);
			@(posedge sys_clk);
			xreq_valid <= 1'b0;
			#1;
			chk(64'({bus_if.agent_cmd[11], bus_if.agent_cmd[7:5], bus_if.agent_cmd[0]}), 64'({1'b0, 3'(c), c[0]}));
			chk(64'(bus_if.agent_ad[63:60]), 64'(c[1] ? 4'h4 : 4'hb));
			wait_hi(2);
			chk(64'({ext_for_me, ext_cmd, ext_req_num, ext_cause, ext_ecc_en}), 64'({xt[c[2:1]], 3'(c), 3'(c), 2'(c), c[0]}));
			chk(64'(ext_addr), 64'(40'h12_3456_7800 + 40'(c)));
			@(posedge sys_clk);
			xdat_valid <= 1'b1;
			xdat_type <= sys_cycle_pkg::data_type_type'(3 - c % 4);
			dat_bad <= c[0];
			dat_word <= 64'hfedc_ba98_7654_3210 ^ 64'(c);
			@(posedge sys_clk);
			xdat_valid <= 1'b0;
			#1;
			chk(64'(bus_if.agent_cmd[11]), 64'h1);
			wait_hi(3);
			chk(64'({ext_dat_bad, ext_dat_type}), 64'({c[0], 2'(3 - c % 4)}));
			chk(ext_dat_word, 64'hfedc_ba98_7654_3210 ^ 64'(c));
		end
	endtask

	// Watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		print_verdict();
	end

	// Main sequence
	initial
	begin
		repeat (11) @(posedge sys_clk);
		#1;
		chk(64'({bus_if.proc_oe, bus_if.agent_oe, preq_valid, ext_valid}), 64'h0);
		@(posedge sys_clk);
		nrst <= 1'b1;
		scen_proc_map();
		scen_coh_mode();
		scen_unc_write();
		scen_proc_data();
		scen_ext();
		print_verdict();
	end
endmodule
